// *** rtl/irp_report.sv ***
// Operation
// - Each report is exactly eight bytes: header, flags, link, media, two PHY register values.
// - The first byte of every report is the constant a1.
// - Flag byte bit 0 is primary remote fault, bit 1 fiber signal detect, bits 7..2 zero.
// - Link byte bit 0 is the internal PHY link state in both modes, one meaning up.
// - In MAC mode link byte bit 1 is the external RMII PHY link state.
// - In PHY mode link byte bit 1 is the inverse of media information bit 8.
// - Link byte bit 2 is set when a bulk-out length field fails parity, else clear.
// - Link byte bit 3 mirrors media information bit 8, which resets to one.
// - Link byte bit 4 is the internal PHY speed, one for 100 Mb/s.
// - Link byte bit 7 is one when the cable is unplugged, bits 6 and 5 are zero.
// - The media byte mirrors media information bits 7..0, resetting to zero.
// - Bytes five and six carry the PHY register chosen by the high select byte.
// - Bytes seven and eight carry the PHY register chosen by the low select byte.
`include "irp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module irp_report #(
    parameter int LW = 11
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire irp_pkg::irp_pins_t pins_async,
    input  wire logic               pm_wr,
    input  wire logic [15:0]        pm_wdata,
    input  wire logic               bo_len_valid,
    input  wire logic [LW-1:0]      bo_len,
    input  wire logic               bo_len_par,
    output logic                    phy_rd_req,
    output logic [7:0]              phy_rd_addr,
    input  wire logic               phy_rd_ack,
    input  wire logic [15:0]        phy_rd_data,
    input  wire logic               ep_poll,
    output logic                    rpt_valid,
    output logic [7:0]              rpt_data,
    output logic                    rpt_last,
    input  wire logic               rpt_ready,
    output logic                    irq
);
    import irp_pkg::*;

    irp_pins_t                pins;
    logic                     len_err;
    logic                     len_err_evt;
    logic                     phy_mode_ff;
    logic [15:0]              sel_ff;
    logic [8:0]               media_ff;
    logic [`IRP_EV_W-1:0]     stat_ff;
    logic [`IRP_EV_W-1:0]     mask_ff;
    logic [31:0]              prdata_ff;
    logic                     pready_ff;
    logic                     pslverr_ff;
    logic                     irq_ff;
    irp_state_t               state_ff;
    logic [15:0]              reg_a_ff;
    logic [63:0]              sh_ff;
    logic [2:0]               idx_ff;
    logic                     rpt_valid_ff;
    logic                     rpt_last_ff;
    logic                     phy_rd_req_ff;
    logic [7:0]               phy_rd_addr_ff;
    logic                     link_prev_ff;
    logic                     sent_evt_ff;
    logic [7:0]               nxt_link;
    irp_report_t              nxt_rpt;
    logic                     wr_go;
    logic [`IRP_EV_W-1:0]     ev;

    // ********************************
    // Pin synchronisers and parity check
    // ********************************
    irp_sync #(.W(6)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (pins_async),
        .dout    (pins)
    );

    irp_lenpar #(.LW(LW)) u_lenpar (
        .pclk      (pclk),
        .presetn   (presetn),
        .len_valid (bo_len_valid),
        .len       (bo_len),
        .len_par   (bo_len_par),
        .err       (len_err),
        .err_evt   (len_err_evt)
    );

    // ********************************
    // Report assembly
    // ********************************
    always_comb begin
        nxt_link    = 8'h00;
        nxt_link[0] = pins.primary_link_up;
        nxt_link[1] = phy_mode_ff ? ~media_ff[8] : pins.ext_link_up;
        nxt_link[2] = len_err;
        nxt_link[3] = media_ff[8];
        nxt_link[4] = pins.internal_phy_speed;
        nxt_link[7] = pins.cable_unplugged;
        nxt_rpt.header = `IRP_HDR;
        nxt_rpt.flags  = {6'h00, pins.fiber_signal_detect, pins.primary_remote_fault};
        nxt_rpt.link   = nxt_link;
        nxt_rpt.media  = media_ff[7:0];
        nxt_rpt.reg_a  = {reg_a_ff[7:0], reg_a_ff[15:8]};
        nxt_rpt.reg_b  = {phy_rd_data[7:0], phy_rd_data[15:8]};
    end

    // ********************************
    // Poll sequencer
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff       <= IRP_IDLE;
            phy_rd_req_ff  <= 1'b0;
            phy_rd_addr_ff <= 8'h00;
            reg_a_ff       <= 16'h0000;
            sh_ff          <= 64'h0;
            idx_ff         <= 3'd0;
            rpt_valid_ff   <= 1'b0;
            rpt_last_ff    <= 1'b0;
            sent_evt_ff    <= 1'b0;
        end else begin
            sent_evt_ff <= 1'b0;
            case (state_ff)
                IRP_IDLE: begin
                    if (ep_poll) begin
                        state_ff       <= IRP_FETCH_A;
                        phy_rd_req_ff  <= 1'b1;
                        phy_rd_addr_ff <= sel_ff[15:8];
                    end
                end
                IRP_FETCH_A: begin
                    if (phy_rd_ack) begin
                        reg_a_ff       <= phy_rd_data;
                        phy_rd_addr_ff <= sel_ff[7:0];
                        state_ff       <= IRP_FETCH_B;
                    end
                end
                IRP_FETCH_B: begin
                    if (phy_rd_ack) begin
                        phy_rd_req_ff <= 1'b0;
                        sh_ff         <= nxt_rpt;
                        idx_ff        <= 3'd0;
                        rpt_valid_ff  <= 1'b1;
                        rpt_last_ff   <= 1'b0;
                        state_ff      <= IRP_SEND;
                    end
                end
                IRP_SEND: begin
                    if (rpt_ready) begin
                        if (rpt_last_ff) begin
                            rpt_valid_ff <= 1'b0;
                            rpt_last_ff  <= 1'b0;
                            sent_evt_ff  <= 1'b1;
                            state_ff     <= IRP_IDLE;
                        end else begin
                            sh_ff       <= {sh_ff[55:0], 8'h00};
                            idx_ff      <= idx_ff + 3'd1;
                            rpt_last_ff <= (idx_ff == `IRP_LAST_IDX - 3'd1);
                        end
                    end
                end
                default: begin
                    state_ff <= IRP_IDLE;
                end
            endcase
        end
    end

    // ********************************
    // Media information from external MAC
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            media_ff <= `IRP_MEDIA_RST;
        end else if (pm_wr) begin
            media_ff <= pm_wdata[8:0];
        end
    end

    // ********************************
    // APB slave
    // ********************************
    assign wr_go = psel && penable && pready_ff && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= psel && !penable;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
            if (psel && !penable) begin
                if (paddr == `IRP_OFF_CTRL) begin
                    prdata_ff <= {31'h0, phy_mode_ff};
                end else if (paddr == `IRP_OFF_SEL) begin
                    prdata_ff <= {16'h0, sel_ff};
                end else if (paddr == `IRP_OFF_MEDIA) begin
                    prdata_ff <= {23'h0, media_ff};
                end else if (paddr == `IRP_OFF_LINK) begin
                    prdata_ff <= {24'h0, nxt_link};
                end else if (paddr == `IRP_OFF_ISTAT) begin
                    prdata_ff <= {28'h0, stat_ff};
                end else if (paddr == `IRP_OFF_IMASK) begin
                    prdata_ff <= {28'h0, mask_ff};
                end else begin
                    pslverr_ff <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_mode_ff <= 1'b0;
            sel_ff      <= `IRP_SEL_RST;
            mask_ff     <= '0;
        end else if (wr_go) begin
            if (paddr == `IRP_OFF_CTRL) begin
                phy_mode_ff <= pwdata[0];
            end else if (paddr == `IRP_OFF_SEL) begin
                sel_ff <= pwdata[15:0];
            end else if (paddr == `IRP_OFF_IMASK) begin
                mask_ff <= pwdata[`IRP_EV_W-1:0];
            end
        end
    end

    // ********************************
    // Interrupt status, set wins over clear
    // ********************************
    always_comb begin
        ev                = '0;
        ev[`IRP_EV_SENT]  = sent_evt_ff;
        ev[`IRP_EV_PAR]   = len_err_evt;
        ev[`IRP_EV_LINK]  = pins.primary_link_up ^ link_prev_ff;
        ev[`IRP_EV_MEDIA] = pm_wr;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff      <= '0;
            link_prev_ff <= 1'b0;
            irq_ff       <= 1'b0;
        end else begin
            link_prev_ff <= pins.primary_link_up;
            irq_ff       <= |(stat_ff & mask_ff);
            if (wr_go && paddr == `IRP_OFF_ISTAT) begin
                stat_ff <= (stat_ff & ~pwdata[`IRP_EV_W-1:0]) | ev;
            end else begin
                stat_ff <= stat_ff | ev;
            end
        end
    end

    assign prdata      = prdata_ff;
    assign pready      = pready_ff;
    assign pslverr     = pslverr_ff;
    assign irq         = irq_ff;
    assign rpt_valid   = rpt_valid_ff;
    assign rpt_data    = sh_ff[63:56];
    assign rpt_last    = rpt_last_ff;
    assign phy_rd_req  = phy_rd_req_ff;
    assign phy_rd_addr = phy_rd_addr_ff;

    // ********************************
    // Assertions
    // ********************************
    property p_len;
        @(posedge pclk) disable iff (!presetn)
        rpt_valid_ff && rpt_last_ff |-> idx_ff == `IRP_LAST_IDX;
    endproperty
    a_len: assert property (p_len) else $error("report length not eight");

    property p_hdr;
        @(posedge pclk) disable iff (!presetn)
        rpt_valid_ff && idx_ff == 3'd0 |-> rpt_data == `IRP_HDR;
    endproperty
    a_hdr: assert property (p_hdr) else $error("bad header byte");

    property p_flags;
        @(posedge pclk) disable iff (!presetn)
        rpt_valid_ff && idx_ff == `IRP_IDX_FLAGS |-> rpt_data[7:2] == 6'h00;
    endproperty
    a_flags: assert property (p_flags) else $error("flag byte spare bits set");

    property p_linkz;
        @(posedge pclk) disable iff (!presetn)
        rpt_valid_ff && idx_ff == `IRP_IDX_LINK |-> rpt_data[6:5] == 2'b00;
    endproperty
    a_linkz: assert property (p_linkz) else $error("link byte spare bits set");

    property p_sec;
        @(posedge pclk) disable iff (!presetn)
        rpt_valid_ff && idx_ff == `IRP_IDX_LINK && phy_mode_ff && !$past(pm_wr, 2)
            |-> rpt_data[`IRP_LINK_SEC] != rpt_data[`IRP_LINK_MED8];
    endproperty
    a_sec: assert property (p_sec) else $error("secondary link not inverse");

    property p_poll;
        @(posedge pclk) disable iff (!presetn)
        state_ff == IRP_IDLE && ep_poll |=> phy_rd_req_ff && phy_rd_addr_ff == $past(sel_ff[15:8]);
    endproperty
    a_poll: assert property (p_poll) else $error("poll did not fetch");

    property p_second;
        @(posedge pclk) disable iff (!presetn)
        state_ff == IRP_FETCH_A && phy_rd_ack |=> phy_rd_addr_ff == $past(sel_ff[7:0]);
    endproperty
    a_second: assert property (p_second) else $error("second fetch address wrong");

    property p_lsb;
        @(posedge pclk) disable iff (!presetn)
        state_ff == IRP_FETCH_B && phy_rd_ack |=> sh_ff[7:0] == $past(phy_rd_data[15:8]);
    endproperty
    a_lsb: assert property (p_lsb) else $error("register byte order wrong");

    property p_media;
        @(posedge pclk) disable iff (!presetn)
        pm_wr ##1 !pm_wr |-> media_ff == $past(pm_wdata[8:0]);
    endproperty
    a_media: assert property (p_media) else $error("media write lost");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        |(stat_ff & mask_ff) |=> irq_ff;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

`default_nettype wire

// *** rtl/irp_cfg.svh ***
`ifndef IRP_CFG_SVH
`define IRP_CFG_SVH

// ********************************
// Report layout
// ********************************
`define IRP_RPT_BYTES   4'd8
`define IRP_HDR         8'ha1
`define IRP_LAST_IDX    3'd7
`define IRP_IDX_FLAGS   3'd1
`define IRP_IDX_LINK    3'd2
`define IRP_IDX_MEDIA   3'd3
`define IRP_LINK_SEC    1
`define IRP_LINK_MED8   3
`define IRP_MEDIA_RST   9'h100
`define IRP_SEL_RST     16'h0100

// ********************************
// Register offsets
// ********************************
`define IRP_OFF_CTRL    12'h000
`define IRP_OFF_SEL     12'h004
`define IRP_OFF_MEDIA   12'h008
`define IRP_OFF_LINK    12'h00c
`define IRP_OFF_ISTAT   12'h010
`define IRP_OFF_IMASK   12'h014

// ********************************
// Interrupt bits
// ********************************
`define IRP_EV_SENT     0
`define IRP_EV_PAR      1
`define IRP_EV_LINK     2
`define IRP_EV_MEDIA    3
`define IRP_EV_W        4

`endif

// *** rtl/irp_pkg.sv ***
package irp_pkg;

    typedef enum logic [1:0] {
        IRP_IDLE    = 2'b00,
        IRP_FETCH_A = 2'b01,
        IRP_FETCH_B = 2'b10,
        IRP_SEND    = 2'b11
    } irp_state_t;

    typedef struct packed {
        logic primary_remote_fault;
        logic fiber_signal_detect;
        logic primary_link_up;
        logic ext_link_up;
        logic internal_phy_speed;
        logic cable_unplugged;
    } irp_pins_t;

    typedef struct packed {
        logic [7:0]  header;
        logic [7:0]  flags;
        logic [7:0]  link;
        logic [7:0]  media;
        logic [15:0] reg_a;
        logic [15:0] reg_b;
    } irp_report_t;

endpackage

// *** rtl/irp_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module irp_sync #(
    parameter int W = 6
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // ********************************
    // Two-stage synchroniser
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;

endmodule

`default_nettype wire

// *** rtl/irp_lenpar.sv ***
`timescale 1ns/1ps
`default_nettype none

module irp_lenpar #(
    parameter int LW = 11
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          len_valid,
    input  wire logic [LW-1:0] len,
    input  wire logic          len_par,
    output logic               err,
    output logic               err_evt
);

    logic err_ff;
    logic err_evt_ff;

    // ********************************
    // Even parity over length and parity bit
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_ff     <= 1'b0;
            err_evt_ff <= 1'b0;
        end else begin
            err_evt_ff <= len_valid && (^{len, len_par});
            if (len_valid) begin
                err_ff <= ^{len, len_par};
            end
        end
    end

    assign err     = err_ff;
    assign err_evt = err_evt_ff;

endmodule

`default_nettype wire

// *** verif/irp_host.sv ***
`timescale 1ns/1ps
`default_nettype none

// ********************************
// Interrupt endpoint poller
// ********************************
module irp_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        go,
    input  wire logic        rpt_valid,
    input  wire logic [7:0]  rpt_data,
    input  wire logic        rpt_last,
    output logic             ep_poll,
    output logic             rpt_ready,
    output logic             done,
    output logic [63:0]      rx,
    output logic [3:0]       nb
);
    logic        busy;
    logic [31:0] st;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ep_poll   <= 1'b0;
            rpt_ready <= 1'b0;
            done      <= 1'b0;
            busy      <= 1'b0;
            rx        <= 64'h0;
            nb        <= 4'h0;
            st        <= 32'hc985;
        end else begin
            st      <= st ^ (st << 13) ^ (st >> 17);
            ep_poll <= go && !busy;
            done    <= 1'b0;
            if (go && !busy) begin
                busy <= 1'b1;
                nb   <= 4'h0;
            end
            // Stall about one byte in four
            rpt_ready <= busy && (st[0] | st[1]);
            if (busy && rpt_valid && rpt_ready) begin
                rx <= {rx[55:0], rpt_data};
                nb <= nb + 4'h1;
                if (rpt_last) begin
                    busy      <= 1'b0;
                    done      <= 1'b1;
                    rpt_ready <= 1'b0;
                end
            end
        end
    end
endmodule

`default_nettype wire

// *** verif/testbench.sv ***
`include "irp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module testbench;
    import irp_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, seed, rs;
    logic        rerr, pm_wr, bo_len_valid, bo_len_par, phy_rd_req, phy_rd_ack;
    logic [15:0] pm_wdata, phy_rd_data, m_sel;
    logic [10:0] bo_len;
    logic [7:0]  phy_rd_addr, rpt_data;
    logic        ep_poll, rpt_valid, rpt_last, rpt_ready, irq, go, done;
    logic [63:0] rx;
    logic [3:0]  nb;
    logic [1:0]  dly;
    logic        m_mode, m_err, any_pm, any_err, any_lk;
    logic [63:0] erp;
    logic [8:0]  m_media;
    irp_pins_t   pins;
    int          errors, n_checks, cyc;
    logic [11:0] offs[4] = '{`IRP_OFF_CTRL, `IRP_OFF_SEL, `IRP_OFF_MEDIA, `IRP_OFF_IMASK};
    logic [31:0] rv[4]   = '{32'h0, 32'h0100, 32'h0100, 32'h0};

    irp_report #(.LW(11)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_async(pins),
        .pm_wr(pm_wr), .pm_wdata(pm_wdata), .bo_len_valid(bo_len_valid),
        .bo_len(bo_len), .bo_len_par(bo_len_par), .phy_rd_req(phy_rd_req),
        .phy_rd_addr(phy_rd_addr), .phy_rd_ack(phy_rd_ack), .phy_rd_data(phy_rd_data),
        .ep_poll(ep_poll), .rpt_valid(rpt_valid), .rpt_data(rpt_data),
        .rpt_last(rpt_last), .rpt_ready(rpt_ready), .irq(irq));

    irp_host host_u (.pclk(pclk), .presetn(presetn), .go(go), .rpt_valid(rpt_valid),
        .rpt_data(rpt_data), .rpt_last(rpt_last), .ep_poll(ep_poll),
        .rpt_ready(rpt_ready), .done(done), .rx(rx), .nb(nb));

    // ********************************
    // Helpers
    // ********************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [15:0] phv(input logic [7:0] a);
        return {a ^ 8'h3c, ~a};
    endfunction

    function automatic logic [63:0] exp_rpt();
        logic [15:0] ra, rb;
        logic [7:0]  lk;
        ra = phv(m_sel[15:8]);
        rb = phv(m_sel[7:0]);
        lk = {pins.cable_unplugged, 2'b00, pins.internal_phy_speed,
              m_media[8], m_err,
              m_mode ? ~m_media[8] : pins.ext_link_up, pins.primary_link_up};
        return {8'ha1, 6'h0, pins.fiber_signal_detect, pins.primary_remote_fault,
                lk, m_media[7:0], ra[7:0], ra[15:8], rb[7:0], rb[15:8]};
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic poll(input string nm);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        while (done !== 1'b1) @(posedge pclk);
        `CHK(nm, exp_rpt(), rx)
        `CHK("byte count", 4'h8, nb)
        @(posedge pclk);
        `CHK("valid after last", 1'b0, rpt_valid)
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ********************************
    // Clock, PHY register responder, watchdog
    // ********************************
    always #10 pclk = ~pclk;

    always @(posedge pclk) begin
        if (phy_rd_ack) begin
            phy_rd_ack  <= 1'b0;
            phy_rd_data <= ~phy_rd_data;
            dly         <= rs[1:0];
            rs          <= xs(rs);
        end else if (phy_rd_req === 1'b1 && dly == 2'd0) begin
            phy_rd_ack  <= 1'b1;
            phy_rd_data <= phv(phy_rd_addr);
        end else begin
            dly         <= (dly == 2'd0) ? 2'd0 : dly - 2'd1;
            phy_rd_data <= ~phy_rd_data;
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            $display("BAD watchdog exp finish got hang");
            finish_test();
        end
    end

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
        pwdata = 0; pm_wr = 0; pm_wdata = 0; bo_len_valid = 0; bo_len = 0;
        bo_len_par = 0; phy_rd_ack = 0; phy_rd_data = 0; go = 0; pins = '0;
        dly = 0; seed = 32'hc985; rs = 32'h1234; errors = 0; n_checks = 0; cyc = 0;
        m_mode = 0; m_media = 9'h100; m_err = 0; m_sel = 16'h0100; any_pm = 0; any_err = 0;
        any_lk = 0; erp = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, offs[i], 32'h0);
            `CHK("reset value", rv[i], rdat)
        end
        apb(1'b0, 12'hffc, 32'h0);
        `CHK("unmapped error", 1'b1, rerr)
        `CHK("unmapped data", 32'h0, rdat)
        $display("test registers done");
        poll("reset report");
        $display("test reset report done");
        repeat (40) begin
            seed = xs(seed);
            any_lk = any_lk | (seed[3] != pins.primary_link_up);
            pins <= irp_pins_t'(seed[5:0]);
            m_mode = seed[6];
            apb(1'b1, `IRP_OFF_CTRL, {31'h0, m_mode});
            m_sel = seed[31:16];
            apb(1'b1, `IRP_OFF_SEL, {16'h0, m_sel});
            if (m_mode) begin
                pm_wr    <= 1'b1;
                pm_wdata <= seed[23:8];
                m_media  = seed[16:8];
                any_pm   = 1'b1;
            end
            bo_len_valid <= 1'b1;
            bo_len       <= seed[18:8];
            bo_len_par   <= seed[19];
            m_err        = ^{seed[18:8], seed[19]};
            any_err      = any_err | m_err;
            @(posedge pclk);
            pm_wr        <= 1'b0;
            bo_len_valid <= 1'b0;
            repeat (4) @(posedge pclk);
            poll("report");
            apb(1'b0, `IRP_OFF_LINK, 32'h0);
            erp = exp_rpt();
            `CHK("link register", {24'h0, erp[47:40]}, rdat)
            `CHK("masked irq", 1'b0, irq)
        end
        $display("test random reports done");
        apb(1'b0, `IRP_OFF_ISTAT, 32'h0);
        `CHK("sent status", 1'b1, rdat[0])
        `CHK("parity status", any_err, rdat[1])
        `CHK("media status", any_pm, rdat[3])
        `CHK("link status", any_lk, rdat[2])
        apb(1'b1, `IRP_OFF_IMASK, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK("irq raised", 1'b1, irq)
        apb(1'b1, `IRP_OFF_ISTAT, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        apb(1'b0, `IRP_OFF_ISTAT, 32'h0);
        `CHK("sent cleared", 1'b0, rdat[0])
        $display("test interrupt done");
        finish_test();
    end
endmodule

`default_nettype wire
